// [bench/hall_sensor_mode_and_rate_control_bench.sv]
module hall_sensor_mode_and_rate_control_bench
    import mode_rate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, rst_n = 1'b0, intCondMet = 1'b0, sclRun = 1'b0, intPull = 1'b0;
    wb_req_t     wbReq = '0;
    sample_t     adcSample = '0;
    logic        wbAck, intPinOut, intPinOeN, convActive, sclIn, intPinIn;
    logic [31:0] wbDatOut, rd, seed = 32'd88002;
    logic [15:0] val;
    logic [2:0]  avg;
    op_mode_t    modeNow;
    int          fails = 0, n_checks = 0;
    always #4 core_clk = ~core_clk;
    hall_mode_ctrl #(.CLK_HZ(1000000)) i_hall_mode_ctrl (.core_clk(core_clk), .rst_n(rst_n),
        .clkEn(1'b1), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .adcSample(adcSample),
        .intCondMet(intCondMet), .sclIn(sclIn), .intPinIn(intPinIn), .intPinOut(intPinOut),
        .intPinOeN(intPinOeN), .convActive(convActive), .modeNow(modeNow));
    host_pins i_host_pins (.sclRun(sclRun), .intPull(intPull), .intPinOeN(intPinOeN),
        .sclIn(sclIn), .intPinIn(intPinIn));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] cw(op_mode_t m, logic [2:0] a, logic [2:0] x, logic t);
        return 32'(m) | (32'(a) << CTRL_AVG_LSB) | (32'(x) << CTRL_AXES_LSB)
            | (32'(t) << CTRL_TRIG_BIT);
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // the slave answers when it likes; only the watchdog ends a stuck wait
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wbReq <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
        do @(posedge core_clk); while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbReq <= '0;
        @(posedge core_clk);
    endtask
    task automatic waitSig(ref logic s, input logic v, input int lim);
        for (int n = 0; n < lim && s !== v; n++) @(posedge core_clk);
        check(s, v);
    endtask
    task waitMode(input op_mode_t m, input int lim);
        for (int n = 0; n < lim && modeNow !== m; n++) @(posedge core_clk);
        check(modeNow, m);
    endtask
    task pinPulse();
        intPull <= 1'b1;
        repeat (3) @(posedge core_clk);
        intPull <= 1'b0;
    endtask
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check(modeNow, MODE_STANDBY);
        check(intPinOeN, 1'b1);
        wb(1'b0, ADDR_CTRL, 0);
        check(rd, cw(MODE_STANDBY, AVG_RESET, AXES_RESET, 1'b0));
        $display("test reset done");
        avg = 3'(rnd() % 6);
        val = 16'(rnd());
        wb(1'b1, ADDR_CTRL, cw(MODE_CONTINUOUS, avg, 3'h1, 1'b0));
        waitMode(MODE_CONTINUOUS, 4);
        waitSig(convActive, 1'b1, 20);
        adcSample <= '{1'b1, 2'd0, val};
        @(posedge core_clk);
        adcSample <= '0;
        wb(1'b0, ADDR_RESULT, 0);
        check(rd, {16'h0, val});
        wb(1'b1, ADDR_CTRL, cw(MODE_STANDBY, 3'h6, 3'h1, 1'b0));
        waitMode(MODE_STANDBY, 4);
        wb(1'b0, ADDR_STATUS, 0);
        check(rd[2], 1'b1);
        wb(1'b0, ADDR_RESULT, 0);
        check(rd, {16'h0, val});
        $display("test continuous done");
        waitSig(convActive, 1'b0, 2000);
        pinPulse();
        waitSig(convActive, 1'b1, 20);
        waitSig(convActive, 1'b0, 2000);
        wb(1'b1, ADDR_CTRL, cw(MODE_STANDBY, 3'h6, 3'h1, 1'b1) | (32'h1 << CTRL_RINT_BIT));
        waitSig(convActive, 1'b1, 6);
        waitSig(convActive, 1'b0, 2000);
        waitSig(intPinOeN, 1'b0, 4);
        waitSig(intPinOeN, 1'b1, 20);
        $display("test trigger done");
        wb(1'b1, ADDR_CTRL, cw(MODE_SLEEP, 3'h6, 3'h1, 1'b0));
        waitMode(MODE_SLEEP, 4);
        sclRun <= 1'b1;
        waitSig(intPinOeN, 1'b0, 100);
        check(intPinOut, 1'b0);
        sclRun <= 1'b0;
        waitMode(MODE_STANDBY, 100);
        check(intPinOeN, 1'b1);
        wb(1'b0, ADDR_RESULT, 0);
        check(rd, 0);
        wb(1'b0, ADDR_STATUS, 0);
        check(rd[STAT_DONE_BIT], 1'b0);
        wb(1'b0, ADDR_CTRL, 0);
        check(rd[4:2], 3'h6);
        wb(1'b1, ADDR_CTRL, cw(MODE_SLEEP, 3'h6, 3'h1, 1'b0));
        pinPulse();
        waitMode(MODE_STANDBY, 20);
        $display("test sleep done");
        wb(1'b1, ADDR_CTRL, cw(MODE_WAKE_SLEEP, 3'h0, 3'h1, 1'b0) | (32'h1 << CTRL_RINT_BIT));
        waitSig(convActive, 1'b1, 1500);
        waitSig(convActive, 1'b0, 200);
        repeat (12) @(posedge core_clk);
        check(modeNow, MODE_WAKE_SLEEP);
        check(intPinOeN, 1'b1);
        wb(1'b0, ADDR_CTRL, 0);
        check(rd, 0);
        waitMode(MODE_STANDBY, 40);
        val = 16'(rnd());
        intCondMet <= 1'b1;
        wb(1'b1, ADDR_CTRL, cw(MODE_WAKE_SLEEP, 3'h0, 3'h1, 1'b0));
        waitSig(convActive, 1'b1, 1500);
        adcSample <= '{1'b1, 2'd0, val};
        @(posedge core_clk);
        adcSample <= '0;
        waitMode(MODE_STANDBY, 200);
        wb(1'b0, ADDR_RESULT, 0);
        check(rd, {16'h0, val});
        $display("test wake-and-sleep done");
        report_and_stop();
    end
endmodule

// [bench/host_pins.sv]
module host_pins (
    input  wire logic sclRun,
    input  wire logic intPull,
    input  wire logic intPinOeN,
    output logic      sclIn,
    output logic      intPinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // link clock stands high between frames; odd start keeps it off the core phase
    initial begin
        sclIn = 1'b1;
        #13;
        forever #40 sclIn = sclRun ? ~sclIn : 1'b1;
    end
    // open-drain wire with pull-up: host or device may pull it low
    assign intPinIn = ~intPull & intPinOeN;
endmodule

// [core/hall_mode_ctrl.sv]
module hall_mode_ctrl
    import mode_rate_pkg::*;
#(
    parameter int unsigned CLK_HZ = CLK_HZ_DEFAULT
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire wb_req_t     wbReq,
    output logic             wbAck,
    output logic      [31:0] wbDatOut,
    input  wire sample_t     adcSample,
    input  wire logic        intCondMet,
    input  wire logic        sclIn,
    input  wire logic        intPinIn,
    output logic             intPinOut,
    output logic             intPinOeN,
    output logic             convActive,
    output op_mode_t         modeNow
);

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_ONE_SHOT,
        ST_SLEEP,
        ST_WAKING,
        ST_WS_SLEEP,
        ST_WS_MEAS,
        ST_CONT
    } state_t;

    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

    state_t      state;
    state_t      next_state;
    logic [2:0]  avgSel;
    logic [2:0]  axesEn;
    logic [3:0]  wakeSel;
    logic        resultIntEn;
    logic        resultStatus;
    logic [3:0]  resultValid;
    logic [31:0] convCnt;
    logic [31:0] msPre;
    logic [14:0] msCnt;
    logic [3:0]  intCnt;
    logic        intDrive;
    logic [2:0]  intDriveDly;
    logic        wbPend;
    logic [1:0]  sclSync;
    logic [1:0]  intSync;
    logic        sclPrev;
    logic        intPrev;
    logic [15:0] storeRd;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclSync <= 2'h3;
            intSync <= 2'h3;
            sclPrev <= 1'h1;
            intPrev <= 1'h1;
        end else if (clkEn) begin
            sclSync <= {sclSync[0], sclIn};
            intSync <= {intSync[0], intPinIn};
            sclPrev <= sclSync[1];
            intPrev <= intSync[1];
        end
    end

    logic sclFall;
    logic intFall;
    assign sclFall = sclPrev & ~sclSync[1];
    // our own drive echoes back through the synchroniser; ignore it
    assign intFall = intPrev & ~intSync[1] & ~intDrive & ~(|intDriveDly);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic wbStart;
    logic wbWrCommit;
    logic accessOk;
    logic ctrlWr;
    logic modeWr;
    logic trigWr;
    logic statusWr;
    logic busWake;
    assign wbStart    = wbReq.cyc & wbReq.stb & ~wbPend & ~wbAck;
    // a write lands on the edge where the master samples ack, not before
    assign wbWrCommit = wbAck & wbReq.cyc & wbReq.stb & wbReq.we;
    assign accessOk   = (state == ST_STANDBY) || (state == ST_ONE_SHOT)
                        || (state == ST_CONT);
    assign ctrlWr     = wbWrCommit & accessOk & (wbReq.adr == ADDR_CTRL) & wbReq.sel[0];
    assign modeWr     = ctrlWr;
    assign trigWr     = ctrlWr & wbReq.sel[1] & wbReq.dat[CTRL_TRIG_BIT];
    assign statusWr   = wbWrCommit & accessOk & (wbReq.adr == ADDR_STATUS) & wbReq.sel[0];
    assign busWake    = wbStart | sclFall;

    // ----------------------------------------------------------------
    // rate and interval tables
    // ----------------------------------------------------------------
    logic [31:0] periodTab [18];
    logic [14:0] wakeMsTab [13];

    for (genvar g = 0; g < 18; g++) begin : g_rate
        assign periodTab[g] =
            32'(CLK_HZ / (RATE_DECI_KSPS[g / 3][g % 3] * HZ_PER_DECI_K));
    end

    for (genvar g = 0; g < 13; g++) begin : g_wake
        assign wakeMsTab[g] = 15'(WAKE_MS[g]);
    end

    logic [2:0]  avgEff;
    logic [1:0]  axIdx;
    logic [1:0]  axCount;
    logic [31:0] periodNow;
    logic [14:0] wakeMsNow;
    // reserved averaging codes run at the slowest rate and are flagged
    assign avgEff    = (avgSel > AVG_SLOWEST) ? AVG_SLOWEST : avgSel;
    assign axCount   = 2'(axesEn[0]) + 2'(axesEn[1]) + 2'(axesEn[2]);
    // temperature alone converts at the single-channel rate
    assign axIdx     = (axCount == 2'h0) ? 2'h0 : axCount - 2'h1;
    assign periodNow = periodTab[5'(avgEff) * 5'h3 + 5'(axIdx)];
    assign wakeMsNow = wakeMsTab[(wakeSel > WAKE_LAST) ? WAKE_LAST : wakeSel];

    logic converting;
    logic doneNow;
    assign converting = (state == ST_ONE_SHOT) || (state == ST_WS_MEAS) || (state == ST_CONT);
    assign doneNow    = converting && (convCnt == 32'h1);

    // ----------------------------------------------------------------
    // mode state machine
    // ----------------------------------------------------------------
    state_t modeTarget;
    always_comb begin
        modeTarget = ST_STANDBY;
        unique case (op_mode_t'(wbReq.dat[CTRL_MODE_LSB +: 2]))
            MODE_STANDBY:    modeTarget = ST_STANDBY;
            MODE_SLEEP:      modeTarget = ST_SLEEP;
            MODE_WAKE_SLEEP: modeTarget = ST_WS_SLEEP;
            MODE_CONTINUOUS: modeTarget = ST_CONT;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_STANDBY: begin
                // a trigger rides on a control write that keeps standby
                if (trigWr && modeTarget == ST_STANDBY) begin
                    next_state = ST_ONE_SHOT;
                end else if (modeWr) begin
                    next_state = modeTarget;
                end else if (intFall) begin
                    next_state = ST_ONE_SHOT;
                end
            end
            ST_ONE_SHOT: begin
                if (modeWr) begin
                    next_state = modeTarget;
                end else if (doneNow) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_CONT: begin
                if (modeWr) begin
                    next_state = modeTarget;
                end
            end
            ST_SLEEP: begin
                if (busWake) begin
                    next_state = ST_WAKING;
                end else if (intFall) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_WAKING: begin
                if (intCnt == 4'h1) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_WS_SLEEP: begin
                if (busWake) begin
                    next_state = ST_WAKING;
                end else if (intFall) begin
                    next_state = ST_STANDBY;
                end else if (msCnt >= wakeMsNow) begin
                    next_state = ST_WS_MEAS;
                end
            end
            ST_WS_MEAS: begin
                if (busWake) begin
                    next_state = ST_WAKING;
                end else if (intFall) begin
                    next_state = ST_STANDBY;
                end else if (doneNow) begin
                    next_state = intCondMet ? ST_STANDBY : ST_WS_SLEEP;
                end
            end
            default: next_state = ST_STANDBY;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= ST_STANDBY;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // conversion and wake timers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            convCnt <= 32'h0;
        end else if (clkEn) begin
            if (!converting || convCnt <= 32'h1) begin
                convCnt <= periodNow;
            end else begin
                convCnt <= convCnt - 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            msPre <= 32'h0;
            msCnt <= 15'h0;
        end else if (clkEn) begin
            if (state != ST_WS_SLEEP) begin
                msPre <= 32'h0;
                msCnt <= 15'h0;
            end else if (msPre >= MS_CYCLES - 1) begin
                msPre <= 32'h0;
                msCnt <= msCnt + 15'h1;
            end else begin
                msPre <= msPre + 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration, kept in every mode
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avgSel      <= AVG_RESET;
            axesEn      <= AXES_RESET;
            wakeSel     <= WAKE_RESET;
            resultIntEn <= 1'h0;
        end else if (clkEn && ctrlWr) begin
            avgSel  <= wbReq.dat[CTRL_AVG_LSB +: 3];
            axesEn  <= wbReq.dat[CTRL_AXES_LSB +: 3];
            if (wbReq.sel[1]) begin
                wakeSel     <= wbReq.dat[CTRL_WAKE_LSB +: 4];
                resultIntEn <= wbReq.dat[CTRL_RINT_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // results
    // ----------------------------------------------------------------
    logic storeWr;
    assign storeWr = adcSample.valid & converting;

    result_store u_store (
        .core_clk (core_clk),
        .clkEn    (clkEn),
        .wrEn     (storeWr),
        .wrAddr   (adcSample.chan),
        .wrData   (adcSample.data),
        .rdAddr   (2'(wbReq.adr[3:2] - 2'h2)),
        .rdData   (storeRd)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            resultValid <= 4'h0;
        end else if (clkEn) begin
            if (state == ST_SLEEP || next_state == ST_SLEEP) begin
                resultValid <= 4'h0;
            end else if (storeWr) begin
                resultValid[adcSample.chan] <= 1'h1;
            end
        end
    end

    // a done in wake-and-sleep only counts when it ends the mode
    logic doneCounts;
    assign doneCounts = doneNow && (state != ST_WS_MEAS || intCondMet);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            resultStatus <= 1'h0;
        end else if (clkEn) begin
            if (doneCounts) begin
                resultStatus <= 1'h1;
            end else if (state == ST_WAKING || state == ST_SLEEP) begin
                resultStatus <= 1'h0;
            end else if (statusWr && wbReq.dat[STAT_DONE_BIT]) begin
                resultStatus <= 1'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt pin, open drain, active low
    // ----------------------------------------------------------------
    logic resultIrq;
    assign resultIrq = doneNow && resultIntEn && (state != ST_WS_MEAS);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            intCnt      <= 4'h0;
            intDrive    <= 1'h0;
            intDriveDly <= 3'h0;
        end else if (clkEn) begin
            intDriveDly <= {intDriveDly[1:0], intDrive};
            if (next_state == ST_WAKING && state != ST_WAKING) begin
                intCnt   <= WAKING_CYC;
                intDrive <= 1'h1;
            end else if (resultIrq || (doneNow && state == ST_WS_MEAS && intCondMet)) begin
                intCnt   <= INT_PULSE_CYC;
                intDrive <= 1'h1;
            end else if (intCnt > 4'h1) begin
                intCnt <= intCnt - 4'h1;
            end else begin
                intCnt   <= 4'h0;
                intDrive <= 1'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // bus slave and status outputs
    // ----------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        if (!accessOk) begin
            rdMux = 32'h0;
        end else if (wbReq.adr == ADDR_CTRL) begin
            rdMux[CTRL_MODE_LSB +: 2] = modeNow;
            rdMux[CTRL_AVG_LSB +: 3]  = avgSel;
            rdMux[CTRL_AXES_LSB +: 3] = axesEn;
            rdMux[CTRL_WAKE_LSB +: 4] = wakeSel;
            rdMux[CTRL_RINT_BIT]      = resultIntEn;
        end else if (wbReq.adr == ADDR_STATUS) begin
            rdMux[STAT_DONE_BIT] = resultStatus;
            rdMux[1]             = converting;
            rdMux[2]             = avgSel > AVG_SLOWEST;
        end else if (wbReq.adr >= ADDR_RESULT && wbReq.adr <= ADDR_RES_LAST
                     && wbReq.adr[1:0] == 2'h0) begin
            rdMux[15:0] = resultValid[2'(wbReq.adr[3:2] - 2'h2)] ? storeRd : 16'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wbPend   <= 1'h0;
            wbAck    <= 1'h0;
            wbDatOut <= 32'h0;
        end else if (clkEn) begin
            wbPend <= wbStart;
            wbAck  <= wbPend;
            if (wbPend) begin
                wbDatOut <= rdMux;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            intPinOut  <= 1'h0;
            intPinOeN  <= 1'h1;
            convActive <= 1'h0;
            modeNow    <= MODE_STANDBY;
        end else if (clkEn) begin
            intPinOut  <= 1'h0;
            intPinOeN  <= ~intDrive;
            convActive <= converting;
            unique case (state)
                ST_SLEEP, ST_WAKING:    modeNow <= MODE_SLEEP;
                ST_WS_SLEEP, ST_WS_MEAS: modeNow <= MODE_WAKE_SLEEP;
                ST_CONT:                modeNow <= MODE_CONTINUOUS;
                default:                modeNow <= MODE_STANDBY;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !clkEn);

    a_reset_standby: assert property ($rose(rst_n) |-> state == ST_STANDBY)
        else $error("not in standby after reset");
    a_mode_write: assert property (modeWr && !(trigWr && state == ST_STANDBY)
        |=> state == $past(modeTarget))
        else $error("mode write not obeyed");
    a_bus_trigger: assert property (trigWr && state == ST_STANDBY
        && modeTarget == ST_STANDBY |=> state == ST_ONE_SHOT)
        else $error("bus trigger did not start conversion");
    a_pin_trigger: assert property (state == ST_STANDBY && intFall && !modeWr
        |=> state == ST_ONE_SHOT && convActive == 1'h0 ##1 convActive)
        else $error("pin trigger did not start conversion");
    a_sleep_drops: assert property (state == ST_SLEEP |-> resultValid == 4'h0)
        else $error("results kept in sleep");
    a_standby_keeps: assert property (state == ST_STANDBY ##1 state == ST_STANDBY
        |-> $stable(resultValid))
        else $error("results changed in standby");
    a_wake_pulse: assert property (state == ST_SLEEP && busWake
        |=> ##1 !intPinOeN [*8] ##1 state == ST_STANDBY && !resultStatus)
        else $error("bus wake pulse wrong");
    a_ws_exit: assert property (state == ST_WS_MEAS && doneNow && intCondMet
        && !busWake && !intFall |=> state == ST_STANDBY && resultStatus)
        else $error("met condition did not end wake-and-sleep");
    a_ws_repeat: assert property (state == ST_WS_MEAS && doneNow && !intCondMet
        && !busWake && !intFall |=> state == ST_WS_SLEEP ##1 intPinOeN)
        else $error("wake-and-sleep did not repeat quietly");
    a_no_access: assert property (wbWrCommit && !accessOk |=> $stable(avgSel) && $stable(state)
        || state == ST_WAKING || state == ST_STANDBY)
        else $error("config written while inaccessible");
    a_rate_fast: assert property (avgEff == 3'h0 && axIdx == 2'h2
        |-> periodNow == CLK_HZ / 10000)
        else $error("fastest rate wrong");
    a_rate_slow: assert property (avgEff == 3'h5 && axIdx == 2'h0
        |-> periodNow == CLK_HZ / 1200)
        else $error("slowest rate wrong");

    c_sleep_wake: cover property (state == ST_SLEEP ##1 state == ST_WAKING);
    c_ws_exit: cover property (state == ST_WS_MEAS ##1 state == ST_STANDBY);
    c_cont_done: cover property (state == ST_CONT && doneNow);

endmodule

// [core/result_store.sv]
module result_store
    import mode_rate_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        clkEn,
    input  wire logic        wrEn,
    input  wire logic [1:0]  wrAddr,
    input  wire logic [15:0] wrData,
    input  wire logic [1:0]  rdAddr,
    output logic      [15:0] rdData
);

    logic [15:0] mem [4];

    always_ff @(posedge core_clk) begin
        if (clkEn && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clkEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// [include/mode_rate_pkg.sv]
// What this block does
// - code 000b: 20.0/13.3/10.0 kSPS by axes
// - code 101b: 1.2/0.6/0.4 kSPS, slowest
// - codes 001b-100b follow the rate table
// - enter the mode written by host
// - settle in standby after power-up
// - standby accepts commands: convert, sleep, transfer
// - conversion starts on bus or pin trigger
// - standby keeps latest results unchanged
// - sleep keeps configuration, drops result data
// - bus or pin wakes sleep into standby
// - bus wake pulses pin, status cleared
// - wake-and-sleep wakes per interval, measures
// - condition met: keep results, go standby
// - condition not met: keep waking and measuring
// - host may force wake during wake-and-sleep
// - no result interrupt in wake-and-sleep
// - continuous converts without pause, results readable
// - register access only in continuous, standby
// - thirteen wake intervals, 1 to 20000 ms
package mode_rate_pkg;

    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_SLEEP,
        MODE_WAKE_SLEEP,
        MODE_CONTINUOUS
    } op_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  chan;
        logic [15:0] data;
    } sample_t;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_RESULT   = 8'h08;
    localparam logic [7:0] ADDR_RES_LAST = 8'h14;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_AVG_LSB  = 2;
    localparam int CTRL_AXES_LSB = 5;
    localparam int CTRL_WAKE_LSB = 8;
    localparam int CTRL_RINT_BIT = 12;
    localparam int CTRL_TRIG_BIT = 13;
    localparam int STAT_DONE_BIT = 0;

    localparam logic [2:0] AVG_RESET   = 3'h0;
    localparam logic [2:0] AXES_RESET  = 3'h7;
    localparam logic [3:0] WAKE_RESET  = 4'h0;
    localparam logic [2:0] AVG_SLOWEST = 3'h5;
    localparam logic [3:0] WAKE_LAST   = 4'hC;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ_DEFAULT = 125_000_000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned HZ_PER_DECI_K  = 100;
    localparam logic [3:0]  INT_PULSE_CYC  = 4'h8;
    localparam logic [3:0]  WAKING_CYC     = 4'h8;

    // rates in tenths of kSPS, per averaging code, for 1/2/3 axes
    localparam int unsigned RATE_DECI_KSPS [0:5][0:2] = '{
        '{200, 133, 100},
        '{133,  80,  57},
        '{ 80,  44,  31},
        '{ 44,  24,  16},
        '{ 24,  12,   8},
        '{ 12,   6,   4}
    };

    localparam int unsigned WAKE_MS [0:12] = '{
        1, 5, 10, 15, 20, 30, 50, 100, 500, 1000, 2000, 5000, 20000
    };

endpackage
